// file: shared/sacs_pkg.sv
/*
  Constants and types shared by the conversion sequencer files.
  Assumes a 40 MHz system clock and an APB slave with 32-bit data.
*/
package sacs_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] SACS_CTRL_OFS = 12'h000; // Control: coding, power down, start
  localparam logic [11:0] SACS_STAT_OFS = 12'h004; // Status: busy, range flags, done count
  localparam logic [11:0] SACS_DATA_OFS = 12'h008; // Result code
  localparam logic [11:0] SACS_RES_OFS = 12'h00c; // Raw resolved bits
  // ==========================================================
  // Field positions
  localparam int SACS_CTRL_CODING_BIT = 0; // Coding select, 1 = twos complement
  localparam int SACS_CTRL_PDOWN_BIT = 1; // Power-down request
  localparam int SACS_CTRL_SWSTART_BIT = 2; // Software start level, active high
  localparam int SACS_STAT_BUSY_BIT = 0;
  localparam int SACS_STAT_OVR_BIT = 1;
  localparam int SACS_STAT_UNDR_BIT = 2;
  localparam logic [2:0] SACS_CTRL_RESET = 3'h0;
  // ==========================================================
  // Code constants
  localparam int SACS_NBITS = 16; // Resolution
  localparam logic [15:0] SACS_CODE_MAX = 16'hffff; // Full scale, straight binary
  localparam logic [15:0] SACS_CODE_MIN = 16'h0000; // Zero scale, straight binary
  localparam logic [15:0] SACS_MSB_FLIP = 16'h8000; // Inverts MSB for twos complement
  // ==========================================================
  // Timing: acquisition time in ns and derived cycles (rounded up)
  localparam int SACS_CLK_NS = 25;
  localparam int SACS_ACQ_NS = 1000;
  localparam int SACS_ACQ_CYC = (SACS_ACQ_NS + SACS_CLK_NS - 1) / SACS_CLK_NS;
  // ==========================================================
  // Sequencer phases
  typedef enum logic [1:0] {SACS_ACQ, SACS_WAIT, SACS_CONV, SACS_FORM} sacs_phase_t;
endpackage : sacs_pkg

// file: hw/sacs_sar_core.sv
/*
  Successive approximation core: a binary search over the weighted
  elements, most significant first, driven by the comparator.
  Assumes the comparator settles within one clock after a switch change.
*/
`timescale 1ns/1ps
module sacs_sar_core #(
  parameter int NBITS = sacs_pkg::SACS_NBITS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic startPulse,
  input wire logic compHigh,
  // Results
  output logic [NBITS-1:0] elemRef,
  output logic [NBITS-1:0] resultBits,
  output logic searchDone
);
  logic [NBITS-1:0] trialMask_r; // One-hot bit under trial
  logic [NBITS-1:0] bits_r; // Bits decided so far plus trial bit
  logic active_r; // Search running
  logic done_r; // One-cycle finish pulse
  logic [NBITS-1:0] elemRef_r; // Element drive, a flop so the comparator sees the current trial

  // ==========================================================
  // Search sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trialMask_r <= '0;
      bits_r <= '0;
      active_r <= 1'b0;
      done_r <= 1'b0;
      elemRef_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (startPulse) begin
        // MSB first: trial half the reference
        trialMask_r <= {1'b1, {(NBITS-1){1'b0}}}; // [RULE_04]
        bits_r <= {1'b1, {(NBITS-1){1'b0}}};
        elemRef_r <= {1'b1, {(NBITS-1){1'b0}}};
        active_r <= 1'b1;
      end else if (active_r) begin
        // Comparator high means the trial overshot: drop the bit
        if (compHigh) begin
          bits_r <= (bits_r & ~trialMask_r) | (trialMask_r >> 1); // [RULE_04]
          elemRef_r <= (bits_r & ~trialMask_r) | (trialMask_r >> 1);
        end else begin
          bits_r <= bits_r | (trialMask_r >> 1);
          elemRef_r <= bits_r | (trialMask_r >> 1);
        end
        trialMask_r <= trialMask_r >> 1;
        if (trialMask_r[0]) begin
          // Last bit decided: release the elements to reference ground
          active_r <= 1'b0;
          done_r <= 1'b1;
          elemRef_r <= '0;
        end
      end
    end
  end

  // Elements at 1 tie to reference, at 0 to reference ground
  assign elemRef = elemRef_r;
  assign resultBits = bits_r;
  assign searchDone = done_r;
endmodule : sacs_sar_core

// file: hw/sacs_sequencer.sv
/*
  Conversion sequencer of a 16-bit successive approximation converter
  with an APB register port.
  Assumes the analog front end supplies a comparator and range flags.
*/
// The implementer's own choices: register access over APB and the address map.
// Overview of operation
// [RULE_01] Acquire: elements on input, common switch closed
// [RULE_02] Start falling edge ends acquisition, begins conversion
// [RULE_03] Conversion start: open switches, tie to ground
// [RULE_04] Sixteen-step MSB-first binary search on elements
// [RULE_05] Form code, then drop busy
// [RULE_06] Result ready when its own conversion ends
// [RULE_07] Straight binary or MSB-inverted twos complement
// [RULE_08] Overrange gives full-scale code
// [RULE_09] Underrange gives minimum code
// [RULE_10] Start already low after acquisition converts immediately
// [RULE_11] Conversion runs to completion, never aborted
// [RULE_12] Power down blocks new conversions only
// [RULE_13] Busy high from start to code ready
// [RULE_14] Coding applied to whole word once
`timescale 1ns/1ps
module sacs_sequencer #(
  parameter int NBITS = sacs_pkg::SACS_NBITS,
  parameter int ACQ_CYC = sacs_pkg::SACS_ACQ_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host pins
  input wire logic convert_start_n,
  input wire logic coding_select,
  input wire logic power_down_request,
  // Analog front end
  input wire logic compHigh,
  input wire logic overRange,
  input wire logic underRange,
  output logic [NBITS-1:0] elemToInput,
  output logic [NBITS-1:0] elemToRef,
  output logic array_common_switch,
  output logic dummy_common_switch,
  output logic dummyToRefGnd,
  // Result
  output logic busy,
  output logic [NBITS-1:0] resultCode
);
  // ==========================================================
  // Pin synchronisers: three stages, change when stages 2 and 3 agree
  logic [2:0] startSync_r;
  logic [2:0] codSync_r;
  logic [2:0] pdSync_r;
  logic startLvl_r; // Filtered start level, active low
  logic codLvl_r;
  logic pdLvl_r;

  // Sync pipelines
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startSync_r <= 3'h7;
      codSync_r <= 3'h0;
      pdSync_r <= 3'h0;
    end else begin
      startSync_r <= {startSync_r[1:0], convert_start_n};
      codSync_r <= {codSync_r[1:0], coding_select};
      pdSync_r <= {pdSync_r[1:0], power_down_request};
    end
  end

  // Filtered levels follow only when stages 2 and 3 agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startLvl_r <= 1'b1;
      codLvl_r <= 1'b0;
      pdLvl_r <= 1'b0;
    end else begin
      if (startSync_r[1] == startSync_r[2]) startLvl_r <= startSync_r[2];
      if (codSync_r[1] == codSync_r[2]) codLvl_r <= codSync_r[2];
      if (pdSync_r[1] == pdSync_r[2]) pdLvl_r <= pdSync_r[2];
    end
  end

  // ==========================================================
  // Control register
  logic [2:0] ctrl_r; // Coding, power down, software start
  logic [15:0] convCount_r; // Completed conversions
  wire swStartN = ~ctrl_r[sacs_pkg::SACS_CTRL_SWSTART_BIT];
  wire startN = startLvl_r & swStartN; // Pin or software may request
  wire codingTwos = codLvl_r | ctrl_r[sacs_pkg::SACS_CTRL_CODING_BIT];
  wire pdown = pdLvl_r | ctrl_r[sacs_pkg::SACS_CTRL_PDOWN_BIT];
  logic startPrev_r;
  wire startFall = startPrev_r & ~startN;

  // Previous start level for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) startPrev_r <= 1'b1;
    else startPrev_r <= startN;
  end

  // ==========================================================
  // Phase machine
  sacs_pkg::sacs_phase_t phase_r;
  logic [$clog2(ACQ_CYC+1)-1:0] acqCnt_r;
  logic convGo;
  logic [NBITS-1:0] coreBits;
  logic coreDone;

  // Start conversion: edge after acquisition, or level already low
  always_comb begin
    convGo = 1'b0;
    case (phase_r)
      sacs_pkg::SACS_ACQ: convGo = (acqCnt_r == '0) && !startN && !pdown; // [RULE_10] [RULE_12]
      sacs_pkg::SACS_WAIT: convGo = startFall && !pdown; // [RULE_02] [RULE_12]
      default: convGo = 1'b0;
    endcase
  end

  // Phase transitions; a running conversion ignores every request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= sacs_pkg::SACS_WAIT;
      acqCnt_r <= '0;
    end else begin
      case (phase_r)
        sacs_pkg::SACS_ACQ: begin
          if (acqCnt_r != '0) acqCnt_r <= acqCnt_r - 1'b1;
          else if (convGo) phase_r <= sacs_pkg::SACS_CONV;
          else phase_r <= sacs_pkg::SACS_WAIT;
        end
        sacs_pkg::SACS_WAIT: begin
          if (convGo) phase_r <= sacs_pkg::SACS_CONV; // [RULE_02]
        end
        sacs_pkg::SACS_CONV: begin
          if (coreDone) phase_r <= sacs_pkg::SACS_FORM; // [RULE_11]
        end
        default: begin
          phase_r <= sacs_pkg::SACS_ACQ;
          acqCnt_r <= ($clog2(ACQ_CYC+1))'(ACQ_CYC - 1);
        end
      endcase
    end
  end

  sacs_sar_core #(.NBITS(NBITS)) uCore (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .startPulse(convGo),
    .compHigh(compHigh),
    .elemRef(elemToRef), // [RULE_04]
    .resultBits(coreBits),
    .searchDone(coreDone)
  );

  // ==========================================================
  // Switch drive
  // Back to tracking on the edge busy drops, so acquisition starts with the result
  wire tracking = (phase_r != sacs_pkg::SACS_CONV) || coreDone;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Reset leaves the array tracking, as in any idle phase
      elemToInput <= '1;
      array_common_switch <= 1'b1;
      dummy_common_switch <= 1'b1;
      dummyToRefGnd <= 1'b0;
    end else begin
      // Tracking only when not about to hold
      array_common_switch <= tracking && !convGo; // [RULE_01] [RULE_03]
      dummy_common_switch <= tracking && !convGo; // [RULE_03]
      elemToInput <= (tracking && !convGo) ? '1 : '0; // [RULE_01]
      dummyToRefGnd <= !(tracking && !convGo); // [RULE_03]
    end
  end

  // ==========================================================
  // Code formation and busy
  logic overLatch_r;
  logic underLatch_r;
  logic [NBITS-1:0] rawBits_r;

  // Clamp on range flags, then apply coding to the whole word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resultCode <= '0;
      busy <= 1'b0;
      overLatch_r <= 1'b0;
      underLatch_r <= 1'b0;
      rawBits_r <= '0;
      convCount_r <= '0;
    end else begin
      if (convGo) begin
        busy <= 1'b1; // [RULE_13]
        overLatch_r <= overRange;
        underLatch_r <= underRange;
      end else if (phase_r == sacs_pkg::SACS_CONV && coreDone) begin
        rawBits_r <= coreBits;
        if (overLatch_r) resultCode <= sacs_pkg::SACS_CODE_MAX ^ (codingTwos ? sacs_pkg::SACS_MSB_FLIP : '0); // [RULE_08]
        else if (underLatch_r) resultCode <= sacs_pkg::SACS_CODE_MIN ^ (codingTwos ? sacs_pkg::SACS_MSB_FLIP : '0); // [RULE_09]
        else resultCode <= coreBits ^ (codingTwos ? sacs_pkg::SACS_MSB_FLIP : '0); // [RULE_07] [RULE_14] [RULE_06]
        busy <= 1'b0; // [RULE_05] [RULE_13]
        convCount_r <= convCount_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // APB slave: zero wait state, unmapped reads zero with error
  wire apbAcc = psel && penable;
  wire hitCtrl = (paddr == sacs_pkg::SACS_CTRL_OFS);
  wire hitStat = (paddr == sacs_pkg::SACS_STAT_OFS);
  wire hitData = (paddr == sacs_pkg::SACS_DATA_OFS);
  wire hitRes = (paddr == sacs_pkg::SACS_RES_OFS);

  // Register write and read answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= sacs_pkg::SACS_CTRL_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        if (hitCtrl) prdata <= {29'h0, ctrl_r};
        else if (hitStat) prdata <= {convCount_r, 13'h0, underLatch_r, overLatch_r, busy};
        else if (hitData) prdata <= {16'h0, resultCode};
        else if (hitRes) prdata <= {16'h0, rawBits_r};
        else pslverr <= 1'b1;
      end
      if (apbAcc && pready && pwrite && hitCtrl) ctrl_r <= pwdata[2:0];
    end
  end
endmodule : sacs_sequencer

// file: verif/sacs_sequencer_asserts.sv
/*
  Checker for the conversion sequencer pins.
  Assumes a bind from tb and range flags held steady by the bench.
*/
`timescale 1ns/1ps
module sacs_sequencer_asserts #(
  parameter int NBITS = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched pins
  input wire logic coding_select,
  input wire logic power_down_request,
  input wire logic overRange,
  input wire logic underRange,
  input wire logic [NBITS-1:0] elemToInput,
  input wire logic array_common_switch,
  input wire logic dummy_common_switch,
  input wire logic dummyToRefGnd,
  input wire logic busy,
  input wire logic [NBITS-1:0] resultCode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Busy length counter, cleared once busy drops
  logic [5:0] busyCnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) busyCnt_r <= 6'h00;
    else busyCnt_r <= busy ? busyCnt_r + 6'h01 : 6'h00;
  end
  // ==========================================================
  // Switch, timing and code properties
  a_track_switches: assert property ((!busy)[*2] |-> elemToInput == '1 && array_common_switch && dummy_common_switch)
    else $error("array not tracking while idle");
  a_conv_switches: assert property (busy |-> !array_common_switch && !dummy_common_switch && dummyToRefGnd && elemToInput == '0)
    else $error("array not held during conversion");
  a_busy_span: assert property ($rose(busy) |-> ##16 busy ##1 !busy)
    else $error("busy span not seventeen cycles");
  a_no_abort: assert property ($fell(busy) |-> busyCnt_r == 6'h11)
    else $error("conversion cut short");
  a_result_hold: assert property (!$fell(busy) |-> $stable(resultCode))
    else $error("result changed outside completion");
  a_power_block: assert property (power_down_request[*8] |=> !$rose(busy))
    else $error("conversion started while powered down");
  a_full_code: assert property ($fell(busy) && overRange && $past(overRange, 18) |-> resultCode == (coding_select ? 16'h7fff : 16'hffff))
    else $error("overrange code wrong");
  a_min_code: assert property ($fell(busy) && underRange && !overRange && $past(underRange, 18) |-> resultCode == (coding_select ? 16'h8000 : 16'h0000))
    else $error("underrange code wrong");
endmodule : sacs_sequencer_asserts

// file: verif/sacs_host_model.sv
/*
  Host controller model: drives start, coding and power-down pins.
  Assumes the bench pulses fire for one cycle between conversions.
*/
`timescale 1ns/1ps
module sacs_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench commands
  input wire logic fire,
  input wire logic hold,
  input wire logic codingIn,
  input wire logic pdIn,
  // Host pins
  output logic convert_start_n,
  output logic coding_select,
  output logic power_down_request
);
  // Low for four cycles, long enough to pass the pin synchroniser
  logic [2:0] lowCnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_r <= 3'h0;
      convert_start_n <= 1'b1;
    end else begin
      lowCnt_r <= fire ? 3'h4 : (lowCnt_r != 3'h0 ? lowCnt_r - 3'h1 : 3'h0);
      convert_start_n <= !(hold || fire || lowCnt_r > 3'h1);
    end
  end
  // Level pins follow the bench one edge later
  always_ff @(posedge clk_sys) begin
    coding_select <= codingIn;
    power_down_request <= pdIn;
  end
endmodule : sacs_host_model

// file: verif/tb.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes an ideal comparator: high while the trial exceeds the sample.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, fire = 1'b0, hold = 1'b0, codingIn = 1'b0, pdIn = 1'b0;
  logic convert_start_n, coding_select, power_down_request, compHigh, overRange = 1'b0, underRange = 1'b0;
  logic [15:0] elemToInput, elemToRef, resultCode, sampleV = 16'h0;
  logic array_common_switch, dummy_common_switch, dummyToRefGnd, busy;
  int errors = 0, total_checks = 0, i;
  // Ideal comparator on the trial word
  assign compHigh = elemToRef > sampleV;
  sacs_sequencer dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .convert_start_n, .coding_select, .power_down_request, .compHigh, .overRange, .underRange, .elemToInput,
    .elemToRef, .array_common_switch, .dummy_common_switch, .dummyToRefGnd, .busy, .resultCode);
  sacs_host_model host (.clk_sys, .rst_n, .fire, .hold, .codingIn, .pdIn, .convert_start_n, .coding_select,
    .power_down_request);
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // Setup cycle, then access held until pready is sampled high; only the watchdog ends a hang
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, busy}, {31'h0, lvl});
  endtask : waitBusy
  function automatic logic [15:0] expCode(input logic [15:0] s, input logic ov, input logic un, input logic cs);
    logic [15:0] v;
    v = ov ? sacs_pkg::SACS_CODE_MAX : (un ? sacs_pkg::SACS_CODE_MIN : s);
    return cs ? v ^ sacs_pkg::SACS_MSB_FLIP : v;
  endfunction : expCode
  // One conversion; pd raises power down in mid-conversion
  task automatic convert(input logic [15:0] s, input logic ov, input logic un, input logic cs, input logic pd);
    sampleV <= s;
    overRange <= ov;
    underRange <= un;
    codingIn <= cs;
    repeat (4) @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    waitBusy(1'b1, 20);
    pdIn <= pd;
    waitBusy(1'b0, 40);
    check({16'h0, resultCode}, {16'h0, expCode(s, ov, un, cs)});
    apb(1'b0, sacs_pkg::SACS_DATA_OFS, 32'h0);
    check(rd, {16'h0, expCode(s, ov, un, cs)});
    repeat (sacs_pkg::SACS_ACQ_CYC + 8) @(posedge clk_sys);
  endtask : convert
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Watchdog, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(81));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, sacs_pkg::SACS_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, sacs_pkg::SACS_CTRL_OFS, 32'h2);
    apb(1'b0, sacs_pkg::SACS_CTRL_OFS, 32'h0);
    check(rd, 32'h2);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (30) @(posedge clk_sys);
    check({31'h0, busy}, 32'h0);
    apb(1'b1, sacs_pkg::SACS_CTRL_OFS, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    convert(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
    convert(16'hffff, 1'b0, 1'b0, 1'b1, 1'b0);
    convert(16'h8000, 1'b0, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 4; i++) convert(16'($urandom), !i[1], i[1], i[0], 1'b0);
    for (i = 0; i < 8; i++) convert(16'($urandom), 1'b0, 1'b0, 1'($urandom), 1'b0);
    $display("test codes done");
    convert(16'($urandom), 1'b0, 1'b0, 1'b0, 1'b1);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (30) @(posedge clk_sys);
    check({31'h0, busy}, 32'h0);
    pdIn <= 1'b0;
    $display("test power down done");
    hold <= 1'b1;
    waitBusy(1'b1, 20);
    waitBusy(1'b0, 40);
    waitBusy(1'b1, sacs_pkg::SACS_ACQ_CYC + 12);
    hold <= 1'b0;
    waitBusy(1'b0, 40);
    $display("test held start done");
    // Software start level and register coding bit, pin coding left at straight binary
    sampleV <= 16'h1234;
    apb(1'b1, sacs_pkg::SACS_CTRL_OFS, 32'h5);
    waitBusy(1'b1, sacs_pkg::SACS_ACQ_CYC + 12);
    apb(1'b1, sacs_pkg::SACS_CTRL_OFS, 32'h1);
    waitBusy(1'b0, 40);
    check({16'h0, resultCode}, {16'h0, expCode(16'h1234, 1'b0, 1'b0, 1'b1)});
    apb(1'b0, sacs_pkg::SACS_RES_OFS, 32'h0);
    check(rd, 32'h00001234);
    apb(1'b1, sacs_pkg::SACS_CTRL_OFS, 32'h0);
    $display("test register start done");
    complete_run();
  end
endmodule : tb
bind sacs_sequencer sacs_sequencer_asserts #(.NBITS(NBITS)) chk (.clk_sys, .rst_n, .coding_select,
  .power_down_request, .overRange, .underRange, .elemToInput, .array_common_switch, .dummy_common_switch,
  .dummyToRefGnd, .busy, .resultCode);
